/* File: cfg_dev_model.sv */
`timescale 1ns/1ps
`include "cfg_msg_consts.vh"

module cfg_dev_model (
    // Clock and pacing
    input wire core_clk,
    input wire slow,
    input wire mute,
    // Request stream
    input wire tx_valid,
    output reg tx_ready,
    input wire tx_ctrl,
    input wire [7:0] tx_byte,
    input wire [31:0] tx_dest,
    // Reply stream
    output reg rx_valid,
    input wire rx_ready,
    output reg rx_ctrl,
    output reg [7:0] rx_byte,
    // Status access
    input wire ps_req,
    input wire [31:0] ps_res_id,
    output reg ps_ack,
    output reg [31:0] ps_rdata
);
    // ----------------------------------------
    // Configuration endpoint behaviour
    // ----------------------------------------
    reg [7:0] m [0:11];
    reg [31:0] regs [0:3];
    reg [31:0] w;
    reg [23:0] rid;
    reg [15:0] r;
    reg done, per, bad;
    integer n, k;
    task snd(input c, input [7:0] b);
        begin
            rx_valid <= 1'h1;
            rx_ctrl <= c;
            rx_byte <= b;
            @(posedge core_clk);
            while (!rx_ready) @(posedge core_clk);
        end
    endtask
    initial begin
        {tx_ready, rx_valid, rx_ctrl, rx_byte, ps_ack, ps_rdata} = 44'h0;
        forever begin
            n = 0;
            done = 1'h0;
            while (!done) begin
                @(posedge core_clk);
                ps_ack <= ps_req && !ps_ack;
                ps_rdata <= ps_res_id ^ 32'hFFFF0000;
                if (tx_valid && tx_ready) begin
                    m[n] = tx_byte;
                    n = n + 1;
                    done = tx_ctrl && tx_byte == `TOK_END && n > 1;
                end
                // Slow mode drops ready every other cycle, so each symbol waits a cycle
                tx_ready <= !done && !(slow && tx_ready);
            end
            rid = {m[1], m[2], m[3]};
            r = {m[4], m[5]};
            per = m[0] == `TOK_PERIPH_READ;
            bad = !per && r > 16'h0003;
            w = per ? {8'h5A, tx_dest[15:8], m[4], m[5]} : regs[r[1:0]];
            if (slow) repeat (3) @(posedge core_clk);
            if (m[0] == `TOK_CFG_WRITE && !bad) regs[r[1:0]] = {m[6], m[7], m[8], m[9]};
            // A wrong destination gets no reply, though a write to it has already updated regs
            if (per ? tx_dest[7:0] != `DEST_PERIPH_LO : tx_dest[15:0] != `DEST_TILE_LO
                && tx_dest[15:0] != `DEST_NODE_LO) begin
            // Mute mode swallows the request so the host must give up on its own
            end else if (!mute && !(m[0] == `TOK_CFG_WRITE && m[3] == `NO_REPLY_LO)) begin
                snd(1'h1, bad ? `TOK_NACK : `TOK_ACK);
                if (!bad && m[0] != `TOK_CFG_WRITE)
                    for (k = 3; k >= 0; k = k - 1) snd(1'h0, w[8*k +: 8]);
                snd(1'h1, `TOK_END);
                rx_valid <= 1'h0;
                rx_byte <= ~rx_byte;
            end
        end
    end
endmodule

/* File: cfg_msg_consts.vh */
`ifndef CFG_MSG_CONSTS_VH
`define CFG_MSG_CONSTS_VH

// ----------------------------------------
// Control tokens
// ----------------------------------------
`define TOK_CFG_WRITE 8'hC0
`define TOK_CFG_READ 8'hC1
`define TOK_PERIPH_READ 8'h25
`define TOK_ACK 8'h03
`define TOK_NACK 8'h04
`define TOK_END 8'h01

// ----------------------------------------
// Destination low patterns and resources
// ----------------------------------------
`define DEST_TILE_LO 16'hC20C
`define DEST_NODE_LO 16'hC30C
`define DEST_PERIPH_LO 8'h02
`define PS_RES_TYPE 8'h0B
`define NO_REPLY_LO 8'hFF

// ----------------------------------------
// Command kinds and targets
// ----------------------------------------
`define KIND_WRITE 2'h0
`define KIND_READ 2'h1
`define KIND_PS_READ 2'h2
`define KIND_PS_WRITE 2'h3
`define TGT_TILE 2'h0
`define TGT_NODE 2'h1
`define TGT_PERIPH 2'h2

// ----------------------------------------
// Message shapes and timing
// ----------------------------------------
`define LAST_IDX_WRITE 4'hA
`define LAST_IDX_SHORT 4'h6
`define REPLY_WAIT_CYC 1024

`endif

/* File: cfg_msg_host.v */
// Function
// - Requests carry 24-bit reply channel-end identifier.
// - Write with reply low byte all ones: no reply expected.
// - Multi-byte fields sent most significant first.
// - Status resource id is register<<8 OR 0x0B.
// - Tile destination is tile id then C20C.
// - Node destination is node id then C30C.
// - Peripheral destination is node, peripheral, 02.
// - Write: 192, reply, register, data, 1.
// - Read: 193, reply, register, then 1.
// - Peripheral read: 37, reply, reg, size, 1.
`timescale 1ns/1ps
`include "cfg_msg_consts.vh"

module cfg_msg_host #(
    parameter REPLY_WAIT = `REPLY_WAIT_CYC
) (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Command port
    input wire cmd_valid,
    output reg cmd_ready_q,
    input wire [1:0] cmd_kind,
    input wire [1:0] cmd_target,
    input wire [15:0] cmd_node_id,
    input wire [7:0] cmd_periph_id,
    input wire [23:0] cmd_reply_id,
    input wire [15:0] cmd_reg,
    input wire [31:0] cmd_data,
    input wire [7:0] cmd_size,
    // Result port
    output reg rsp_valid_q,
    output reg rsp_ok_q,
    output reg rsp_timeout_q,
    output reg [31:0] rsp_data_q,
    // Token stream towards the device
    output reg tx_valid_q,
    input wire tx_ready,
    output reg tx_ctrl_q,
    output reg [7:0] tx_byte_q,
    output reg [31:0] tx_dest_q,
    // Token stream from the device
    input wire rx_valid,
    output reg rx_ready_q,
    input wire rx_ctrl,
    input wire [7:0] rx_byte,
    // Processor status access
    output reg ps_req_q,
    output reg ps_write_q,
    output reg [31:0] ps_res_id_q,
    output reg [31:0] ps_wdata_q,
    input wire ps_ack,
    input wire [31:0] ps_rdata
);

    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam S_IDLE = 3'h0;
    localparam S_SEND = 3'h1;
    localparam S_HEAD = 3'h2;
    localparam S_BODY = 3'h3;
    localparam S_PS = 3'h4;

    localparam MT_WRITE = 2'h0;
    localparam MT_READ = 2'h1;
    localparam MT_PREAD = 2'h2;

    reg [2:0] state_q;
    reg [1:0] mt_q;
    reg [23:0] reply_q;
    reg [15:0] reg_q;
    reg [31:0] data_q;
    reg [7:0] size_q;
    reg [3:0] idx_q;
    reg sent_all_q;
    reg ok_q;
    reg [15:0] wait_q;

    reg [7:0] sym_byte;
    reg sym_ctrl;
    wire [3:0] last_idx;
    wire no_reply;
    wire rx_take;
    wire timed_out;

    assign last_idx = (mt_q == MT_WRITE) ? `LAST_IDX_WRITE : `LAST_IDX_SHORT;
    assign no_reply = (mt_q == MT_WRITE) && (reply_q[7:0] == `NO_REPLY_LO);
    assign rx_take = rx_valid && rx_ready_q;
    assign timed_out = (wait_q == REPLY_WAIT[15:0] - 16'h0001);

    // ----------------------------------------
    // Outgoing symbol for the current position
    // ----------------------------------------
    always @* begin
        sym_ctrl = 1'b0;
        sym_byte = 8'h00;
        case (idx_q)
            4'h0: begin
                sym_ctrl = 1'b1;
                if (mt_q == MT_WRITE) begin
                    sym_byte = `TOK_CFG_WRITE;
                end else if (mt_q == MT_READ) begin
                    sym_byte = `TOK_CFG_READ;
                end else begin
                    sym_byte = `TOK_PERIPH_READ;
                end
            end
            // Reply identifier, most significant byte first
            4'h1: sym_byte = reply_q[23:16];
            4'h2: sym_byte = reply_q[15:8];
            4'h3: sym_byte = reply_q[7:0];
            4'h4: begin
                if (mt_q == MT_PREAD) begin
                    sym_byte = reg_q[7:0];
                end else begin
                    sym_byte = reg_q[15:8];
                end
            end
            4'h5: begin
                if (mt_q == MT_PREAD) begin
                    sym_byte = size_q;
                end else begin
                    sym_byte = reg_q[7:0];
                end
            end
            4'h6: begin
                if (mt_q == MT_WRITE) begin
                    sym_byte = data_q[31:24];
                end else begin
                    sym_ctrl = 1'b1;
                    sym_byte = `TOK_END;
                end
            end
            4'h7: sym_byte = data_q[23:16];
            4'h8: sym_byte = data_q[15:8];
            4'h9: sym_byte = data_q[7:0];
            4'hA: begin
                sym_ctrl = 1'b1;
                sym_byte = `TOK_END;
            end
            default: begin
                sym_ctrl = 1'b0;
                sym_byte = 8'h00;
            end
        endcase
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
            cmd_ready_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_ok_q <= 1'b0;
            rsp_timeout_q <= 1'b0;
            rsp_data_q <= 32'h00000000;
            tx_valid_q <= 1'b0;
            tx_ctrl_q <= 1'b0;
            tx_byte_q <= 8'h00;
            tx_dest_q <= 32'h00000000;
            rx_ready_q <= 1'b0;
            ps_req_q <= 1'b0;
            ps_write_q <= 1'b0;
            ps_res_id_q <= 32'h00000000;
            ps_wdata_q <= 32'h00000000;
            mt_q <= MT_WRITE;
            reply_q <= 24'h000000;
            reg_q <= 16'h0000;
            data_q <= 32'h00000000;
            size_q <= 8'h00;
            idx_q <= 4'h0;
            sent_all_q <= 1'b0;
            ok_q <= 1'b0;
            wait_q <= 16'h0000;
        end else begin
            rsp_valid_q <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    cmd_ready_q <= 1'b1;
                    if (cmd_valid && cmd_ready_q) begin
                        cmd_ready_q <= 1'b0;
                        reply_q <= cmd_reply_id;
                        reg_q <= cmd_reg;
                        data_q <= cmd_data;
                        size_q <= cmd_size;
                        idx_q <= 4'h0;
                        sent_all_q <= 1'b0;
                        wait_q <= 16'h0000;
                        rsp_timeout_q <= 1'b0;
                        rsp_data_q <= 32'h00000000;
                        if (cmd_kind == `KIND_PS_READ || cmd_kind == `KIND_PS_WRITE) begin
                            ps_req_q <= 1'b1;
                            ps_write_q <= (cmd_kind == `KIND_PS_WRITE);
                            ps_res_id_q <= {8'h00, cmd_reg, `PS_RES_TYPE};
                            ps_wdata_q <= cmd_data;
                            state_q <= S_PS;
                        end else if (cmd_target == `TGT_PERIPH &&
                                cmd_kind == `KIND_WRITE) begin
                            // Peripheral write framing is not supported; refuse
                            rsp_valid_q <= 1'b1;
                            rsp_ok_q <= 1'b0;
                        end else begin
                            if (cmd_target == `TGT_PERIPH) begin
                                mt_q <= MT_PREAD;
                                tx_dest_q <= {cmd_node_id, cmd_periph_id,
                                    `DEST_PERIPH_LO};
                            end else begin
                                mt_q <= (cmd_kind == `KIND_WRITE) ? MT_WRITE : MT_READ;
                                if (cmd_target == `TGT_NODE) begin
                                    tx_dest_q <= {cmd_node_id, `DEST_NODE_LO};
                                end else begin
                                    tx_dest_q <= {cmd_node_id, `DEST_TILE_LO};
                                end
                            end
                            state_q <= S_SEND;
                        end
                    end
                end
                S_SEND: begin
                    if (!tx_valid_q || tx_ready) begin
                        if (sent_all_q) begin
                            tx_valid_q <= 1'b0;
                            if (no_reply) begin
                                // Fire-and-forget write completes on its last token
                                rsp_valid_q <= 1'b1;
                                rsp_ok_q <= 1'b1;
                                state_q <= S_IDLE;
                            end else begin
                                rx_ready_q <= 1'b1;
                                state_q <= S_HEAD;
                            end
                        end else begin
                            tx_valid_q <= 1'b1;
                            tx_ctrl_q <= sym_ctrl;
                            tx_byte_q <= sym_byte;
                            idx_q <= idx_q + 4'h1;
                            sent_all_q <= (idx_q == last_idx);
                        end
                    end
                end
                S_HEAD: begin
                    wait_q <= wait_q + 16'h0001;
                    if (rx_take) begin
                        wait_q <= 16'h0000;
                        // Anything but an ack token counts as failure
                        ok_q <= rx_ctrl && (rx_byte == `TOK_ACK);
                        state_q <= S_BODY;
                    end else if (timed_out) begin
                        rx_ready_q <= 1'b0;
                        rsp_valid_q <= 1'b1;
                        rsp_ok_q <= 1'b0;
                        rsp_timeout_q <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
                S_BODY: begin
                    wait_q <= wait_q + 16'h0001;
                    if (rx_take) begin
                        wait_q <= 16'h0000;
                        if (rx_ctrl) begin
                            // End token closes the reply; a failure reply also
                            // covers unimplemented register numbers
                            rx_ready_q <= 1'b0;
                            rsp_valid_q <= 1'b1;
                            rsp_ok_q <= ok_q && (rx_byte == `TOK_END);
                            state_q <= S_IDLE;
                        end else begin
                            // Data arrives MSB first; the last four bytes stay
                            rsp_data_q <= {rsp_data_q[23:0], rx_byte};
                        end
                    end else if (timed_out) begin
                        rx_ready_q <= 1'b0;
                        rsp_valid_q <= 1'b1;
                        rsp_ok_q <= 1'b0;
                        rsp_timeout_q <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
                S_PS: begin
                    if (ps_ack) begin
                        ps_req_q <= 1'b0;
                        rsp_valid_q <= 1'b1;
                        rsp_ok_q <= 1'b1;
                        if (!ps_write_q) begin
                            rsp_data_q <= ps_rdata;
                        end
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

endmodule

/* File: cfg_msg_host_bench.sv */
`timescale 1ns/1ps
`include "cfg_msg_consts.vh"

module cfg_msg_host_bench;
    // ----------------------------------------
    // Stimulus and checking
    // ----------------------------------------
    reg core_clk, rst_n, cmd_valid, slow, mute, saw;
    reg [1:0] cmd_kind, cmd_target;
    reg [15:0] cmd_node_id, cmd_reg;
    reg [7:0] cmd_periph_id, cmd_size;
    reg [23:0] cmd_reply_id;
    reg [31:0] cmd_data;
    wire cmd_ready_q, rsp_valid_q, rsp_ok_q, rsp_timeout_q, tx_valid_q, tx_ready, tx_ctrl_q;
    wire rx_valid, rx_ready_q, rx_ctrl, ps_req_q, ps_write_q, ps_ack;
    wire [7:0] tx_byte_q, rx_byte;
    wire [31:0] rsp_data_q, tx_dest_q, ps_res_id_q, ps_wdata_q, ps_rdata;
    integer fail_count, compares, n;
    cfg_msg_host #(.REPLY_WAIT(16)) dut (.core_clk(core_clk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_ready_q(cmd_ready_q), .cmd_kind(cmd_kind),
        .cmd_target(cmd_target), .cmd_node_id(cmd_node_id), .cmd_periph_id(cmd_periph_id),
        .cmd_reply_id(cmd_reply_id), .cmd_reg(cmd_reg), .cmd_data(cmd_data),
        .cmd_size(cmd_size), .rsp_valid_q(rsp_valid_q), .rsp_ok_q(rsp_ok_q),
        .rsp_timeout_q(rsp_timeout_q), .rsp_data_q(rsp_data_q), .tx_valid_q(tx_valid_q),
        .tx_ready(tx_ready), .tx_ctrl_q(tx_ctrl_q), .tx_byte_q(tx_byte_q),
        .tx_dest_q(tx_dest_q), .rx_valid(rx_valid), .rx_ready_q(rx_ready_q),
        .rx_ctrl(rx_ctrl), .rx_byte(rx_byte), .ps_req_q(ps_req_q), .ps_write_q(ps_write_q),
        .ps_res_id_q(ps_res_id_q), .ps_wdata_q(ps_wdata_q), .ps_ack(ps_ack),
        .ps_rdata(ps_rdata));
    cfg_dev_model dev (.core_clk(core_clk), .slow(slow), .mute(mute), .tx_valid(tx_valid_q),
        .tx_ready(tx_ready), .tx_ctrl(tx_ctrl_q), .tx_byte(tx_byte_q), .tx_dest(tx_dest_q),
        .rx_valid(rx_valid), .rx_ready(rx_ready_q), .rx_ctrl(rx_ctrl), .rx_byte(rx_byte),
        .ps_req(ps_req_q), .ps_res_id(ps_res_id_q), .ps_ack(ps_ack), .ps_rdata(ps_rdata));
    task finish_test;
        begin
            if (fail_count == 0 && compares > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    task chk(input [95:0] nm, input [31:0] seen, input [31:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("[ERR] %0s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task wt;
        begin
            @(negedge core_clk);
            n = n + 1;
            if (n > 300) begin
                fail_count = fail_count + 1;
                finish_test;
            end
        end
    endtask
    // One whole transaction; saw notes whether a reply was ever awaited
    task run(input [1:0] k, input [1:0] t, input [15:0] r, input [31:0] d, input [23:0] id);
        begin
            @(negedge core_clk);
            {cmd_kind, cmd_target, cmd_reg, cmd_data, cmd_reply_id} = {k, t, r, d, id};
            cmd_valid = 1'h1;
            saw = 1'h0;
            n = 0;
            while (cmd_ready_q !== 1'h1) wt;
            @(negedge core_clk);
            cmd_valid = 1'h0;
            while (rsp_valid_q !== 1'h1) begin
                saw = saw | (rx_ready_q === 1'h1);
                wt;
            end
        end
    endtask
    task t_cfg;
        begin
            run(`KIND_WRITE, `TGT_TILE, 16'h0002, 32'h89ABCDEF, 24'h123400);
            chk("wr ok", rsp_ok_q, 1'h1);
            chk("reply id", dev.rid, 24'h123400);
            run(`KIND_READ, `TGT_NODE, 16'h0002, 32'h0, 24'h5678AB);
            chk("rd ok", rsp_ok_q, 1'h1);
            chk("rd data", rsp_data_q, 32'h89ABCDEF);
            chk("tx idle", tx_valid_q, 1'h0);
            chk("rx idle", rx_ready_q, 1'h0);
        end
    endtask
    // A silent endpoint must end in a timed-out failure, not a hang
    task t_late;
        begin
            mute = 1'h1;
            run(`KIND_READ, `TGT_TILE, 16'h0001, 32'h0, 24'h123400);
            chk("late ok", rsp_ok_q, 1'h0);
            chk("late flag", rsp_timeout_q, 1'h1);
            mute = 1'h0;
        end
    endtask
    task t_bad;
        begin
            run(`KIND_WRITE, `TGT_NODE, 16'h0009, 32'h1, 24'h000100);
            chk("bad wr", rsp_ok_q, 1'h0);
            chk("bad wr to", rsp_timeout_q, 1'h0);
            run(`KIND_READ, 2'h3, 16'h0100, 32'h0, 24'h000100);
            chk("bad rd", rsp_ok_q, 1'h0);
        end
    endtask
    task t_quiet;
        begin
            run(`KIND_WRITE, `TGT_TILE, 16'h0001, 32'h00C0FFEE, 24'h1234FF);
            chk("no reply", saw, 1'h0);
            run(`KIND_READ, `TGT_TILE, 16'h0001, 32'h0, 24'h123400);
            chk("quiet data", rsp_data_q, 32'h00C0FFEE);
        end
    endtask
    task t_periph;
        begin
            slow = 1'h1;
            run(`KIND_READ, `TGT_PERIPH, 16'h0056, 32'h0, 24'h123400);
            chk("per data", rsp_data_q, {8'h5A, 8'h34, 8'h56, 8'h04});
            slow = 1'h0;
        end
    endtask
    task t_status;
        begin
            run(`KIND_PS_READ, `TGT_TILE, 16'h0007, 32'h0, 24'h0);
            chk("ps data", rsp_data_q, 32'h0000070B ^ 32'hFFFF0000);
            run(`KIND_PS_WRITE, `TGT_TILE, 16'h0002, 32'h0000A5A5, 24'h0);
            chk("ps wdata", ps_wdata_q, 32'h0000A5A5);
        end
    endtask
    initial begin
        {core_clk, rst_n, cmd_valid, slow, mute, saw} = 6'h0;
        {cmd_kind, cmd_target, cmd_reg, cmd_data, cmd_reply_id} = 76'h0;
        {cmd_node_id, cmd_periph_id, cmd_size} = 32'h00123404;
        fail_count = 0;
        compares = 0;
        repeat (3) @(negedge core_clk);
        rst_n = 1'h1;
        t_cfg;
        t_late;
        t_bad;
        t_quiet;
        t_periph;
        t_status;
        finish_test;
    end
    initial forever #12.5 core_clk = ~core_clk;
endmodule

/* File: cfg_msg_host_sva.sv */
`timescale 1ns/1ps
`include "cfg_msg_consts.vh"

module cfg_msg_host_sva (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Command side
    input wire cmd_valid,
    input wire cmd_ready_q,
    input wire [1:0] cmd_kind,
    input wire [1:0] cmd_target,
    input wire [15:0] cmd_node_id,
    input wire [7:0] cmd_periph_id,
    input wire [15:0] cmd_reg,
    input wire rsp_valid_q,
    input wire rsp_ok_q,
    // Device side
    input wire tx_ctrl_q,
    input wire [7:0] tx_byte_q,
    input wire [31:0] tx_dest_q,
    input wire rx_valid,
    input wire rx_ready_q,
    input wire rx_ctrl,
    input wire [7:0] rx_byte,
    input wire ps_req_q,
    input wire ps_write_q,
    input wire [31:0] ps_res_id_q,
    input wire ps_ack
);
    // ----------------------------------------
    // Message framing and status access checks
    // ----------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire take = cmd_valid && cmd_ready_q;
    // Peripheral writes are refused, so only peripheral reads open a message
    wire msg = take && !cmd_kind[1] && (cmd_target != 2'h2 || cmd_kind[0]);
    // The opening token is loaded one cycle after the destination
    wr_token_a: assert property (
        msg && !cmd_kind[0] |=> ##1 tx_ctrl_q && tx_byte_q == `TOK_CFG_WRITE)
        else $error("write token wrong");
    rd_token_a: assert property (
        msg && cmd_kind[0] && cmd_target != 2'h2
        |=> ##1 tx_ctrl_q && tx_byte_q == `TOK_CFG_READ)
        else $error("read token wrong");
    tile_dest_a: assert property (
        msg && (cmd_target == 2'h0 || cmd_target == 2'h3)
        |=> tx_dest_q == {$past(cmd_node_id), `DEST_TILE_LO}) else $error("tile dest wrong");
    node_dest_a: assert property (
        msg && cmd_target == 2'h1 |=> tx_dest_q == {$past(cmd_node_id), `DEST_NODE_LO})
        else $error("node dest wrong");
    periph_read_a: assert property (
        msg && cmd_target == 2'h2
        |=> tx_dest_q == {$past(cmd_node_id), $past(cmd_periph_id), `DEST_PERIPH_LO}
        ##1 tx_ctrl_q && tx_byte_q == `TOK_PERIPH_READ)
        else $error("peripheral read start wrong");
    ps_res_a: assert property (
        take && cmd_kind[1] |=> ps_req_q && ps_write_q == $past(cmd_kind[0])
        && ps_res_id_q == {8'h00, $past(cmd_reg), `PS_RES_TYPE}) else $error("status id wrong");
    ps_done_a: assert property (
        ps_req_q && ps_ack |=> rsp_valid_q && !ps_req_q) else $error("status access not closed");
    nack_fail_a: assert property (
        rx_valid && rx_ready_q && rx_ctrl && rx_byte == `TOK_NACK
        |-> ##[1:4] rsp_valid_q && !rsp_ok_q) else $error("failure reply not reported");
endmodule

bind cfg_msg_host cfg_msg_host_sva chk_i (.core_clk(core_clk), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_ready_q(cmd_ready_q), .cmd_kind(cmd_kind),
    .cmd_target(cmd_target), .cmd_node_id(cmd_node_id), .cmd_periph_id(cmd_periph_id),
    .cmd_reg(cmd_reg), .rsp_valid_q(rsp_valid_q), .rsp_ok_q(rsp_ok_q),
    .tx_ctrl_q(tx_ctrl_q), .tx_byte_q(tx_byte_q), .tx_dest_q(tx_dest_q),
    .rx_valid(rx_valid), .rx_ready_q(rx_ready_q), .rx_ctrl(rx_ctrl), .rx_byte(rx_byte),
    .ps_req_q(ps_req_q), .ps_write_q(ps_write_q), .ps_res_id_q(ps_res_id_q), .ps_ack(ps_ack));
